/* atsm_tx_mapper.sv */
// Transmit slot mapper for output channels one to three of the primary serial audio port.
// Assumes bit clock and frame sync arrive from pins and are far slower than mclk.
// Operation
// RQ1 - Channel one: off tri-states, on sends converter data
// RQ2 - Channel two: off tri-states, on sends converter data
// RQ3 - Channel three source: tri, mic, battery, reserved
// RQ4 - TDM: slot equals five-bit field, 0 to 31
// RQ5 - I2S/LJ: 0-15 left, 16-31 right slots
// RQ6 - Reset slots are 0, 1 and 2
// RQ7 - Reserved config bits read zero, write zero
// RQ8 - Pin-select bit picks primary or secondary pin
// RQ9 - Slot zero MSB delayed 0 to 31 bit clocks
`timescale 1ns/10ps
`default_nettype none

module atsm_tx_mapper #(
    parameter int SAMPLE_W = atsm_pkg::SAMPLE_W
) (
    input  wire logic                mclk,
    input  wire logic                reset,
    input  wire logic [7:0]          reg_addr,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    input  wire logic [7:0]          reg_wdata,
    output logic      [7:0]          reg_rdata,
    input  wire logic [1:0]          fmt,
    input  wire logic [1:0]          word_len_sel,
    input  wire logic                bclk_pin,
    input  wire logic                fsync_pin,
    input  wire logic [SAMPLE_W-1:0] ch1_sample,
    input  wire logic [SAMPLE_W-1:0] ch2_sample,
    input  wire logic [SAMPLE_W-1:0] ch3_mic_sample,
    input  wire logic [SAMPLE_W-1:0] ch3_vbat_sample,
    output logic                     dout_o,
    output logic                     dout_oe_n,
    output logic                     secondary_serial_out_pin_o,
    output logic                     secondary_serial_out_pin_oe_n
);

    if (SAMPLE_W != 32) begin : g_bad_width
        $error("atsm_tx_mapper: SAMPLE_W must be 32");
    end

    // ------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------
    logic [7:0] delay_reg;
    logic [7:0] pin_sel_reg;
    logic [7:0] ch1_cfg_reg;
    logic [7:0] ch2_cfg_reg;
    logic [7:0] ch3_cfg_reg;
    logic [7:0] rdata_next;
    logic [7:0] reg_rdata_reg;

    // Reserved bits are masked on write so they always read back as zero
    always_ff @(posedge mclk) begin
        if (reset) begin
            delay_reg   <= atsm_pkg::SLOT_ZERO_MSB_DELAY_RST;
            pin_sel_reg <= atsm_pkg::OUT_PIN_SEL_RST;
            ch1_cfg_reg <= atsm_pkg::OUT_CH_ONE_CONFIG_RST;   // [RQ1] [RQ6]
            ch2_cfg_reg <= atsm_pkg::OUT_CH_TWO_CONFIG_RST;   // [RQ2] [RQ6]
            ch3_cfg_reg <= atsm_pkg::OUT_CH_THREE_CONFIG_RST; // [RQ3] [RQ6]
        end else if (reg_wr) begin
            if (reg_addr == atsm_pkg::SLOT_ZERO_MSB_DELAY_ADDR)
                delay_reg <= reg_wdata & atsm_pkg::DELAY_MASK;
            else if (reg_addr == atsm_pkg::OUT_PIN_SEL_ADDR)
                pin_sel_reg <= reg_wdata & atsm_pkg::PIN_SEL_MASK;
            else if (reg_addr == atsm_pkg::OUT_CH_ONE_CONFIG_ADDR)
                ch1_cfg_reg <= reg_wdata & atsm_pkg::CH12_MASK;  // [RQ7]
            else if (reg_addr == atsm_pkg::OUT_CH_TWO_CONFIG_ADDR)
                ch2_cfg_reg <= reg_wdata & atsm_pkg::CH12_MASK;  // [RQ7]
            else if (reg_addr == atsm_pkg::OUT_CH_THREE_CONFIG_ADDR)
                ch3_cfg_reg <= reg_wdata & atsm_pkg::CH3_MASK;   // [RQ7]
        end
    end

    always_comb begin
        if (reg_addr == atsm_pkg::SLOT_ZERO_MSB_DELAY_ADDR) rdata_next = delay_reg;
        else if (reg_addr == atsm_pkg::OUT_PIN_SEL_ADDR) rdata_next = pin_sel_reg;
        else if (reg_addr == atsm_pkg::OUT_CH_ONE_CONFIG_ADDR) rdata_next = ch1_cfg_reg;
        else if (reg_addr == atsm_pkg::OUT_CH_TWO_CONFIG_ADDR) rdata_next = ch2_cfg_reg;
        else if (reg_addr == atsm_pkg::OUT_CH_THREE_CONFIG_ADDR) rdata_next = ch3_cfg_reg;
        else rdata_next = 8'h00;
    end

    always_ff @(posedge mclk) begin
        if (reset) reg_rdata_reg <= 8'h00;
        else if (reg_rd) reg_rdata_reg <= rdata_next;
    end

    assign reg_rdata = reg_rdata_reg;

    // ------------------------------------------------------------------
    // Pin synchronisers and edge detection
    // ------------------------------------------------------------------
    logic bclk_s1_reg;
    logic bclk_s2_reg;
    logic bclk_s3_reg;
    logic fsync_s1_reg;
    logic fsync_s2_reg;
    logic fsync_prev_reg;

    always_ff @(posedge mclk) begin
        if (reset) begin
            bclk_s1_reg  <= 1'b0;
            bclk_s2_reg  <= 1'b0;
            bclk_s3_reg  <= 1'b0;
            fsync_s1_reg <= 1'b0;
            fsync_s2_reg <= 1'b0;
        end else begin
            bclk_s1_reg  <= bclk_pin;
            bclk_s2_reg  <= bclk_s1_reg;
            bclk_s3_reg  <= bclk_s2_reg;
            fsync_s1_reg <= fsync_pin;
            fsync_s2_reg <= fsync_s1_reg;
        end
    end

    wire bclk_rise = bclk_s2_reg & ~bclk_s3_reg;
    wire bclk_fall = ~bclk_s2_reg & bclk_s3_reg;

    // Frame sync is taken on bit-clock rising edges only, as the host drives it
    always_ff @(posedge mclk) begin
        if (reset) fsync_prev_reg <= 1'b0;
        else if (bclk_rise) fsync_prev_reg <= fsync_s2_reg;
    end

    // ------------------------------------------------------------------
    // Framing decode
    // ------------------------------------------------------------------
    wire        is_tdm     = (fmt == atsm_pkg::FMT_TDM);
    wire        is_i2s     = (fmt == atsm_pkg::FMT_I2S);
    wire        fs_rise    = fsync_s2_reg & ~fsync_prev_reg;
    wire        fs_change  = fsync_s2_reg ^ fsync_prev_reg;
    wire        frame_start = is_tdm ? fs_rise : fs_change;
    wire        right_next = is_i2s ? fsync_s2_reg : ~fsync_s2_reg;
    wire [5:0]  delay_ext  = {1'b0, delay_reg[atsm_pkg::DELAY_W-1:0]};
    // I2S places the MSB one bit clock after the sync edge
    wire [5:0]  delay_eff  = is_i2s ? 6'(delay_ext + atsm_pkg::I2S_EXTRA_BITS) : delay_ext;
    wire [4:0]  last_bit   = atsm_pkg::word_last(word_len_sel);
    wire [4:0]  last_slot  = is_tdm ? atsm_pkg::TDM_LAST_SLOT : atsm_pkg::HALF_LAST_SLOT;
    wire        start_now  = bclk_rise & frame_start;
    // Samples are latched once per frame so left and right come from one set
    wire        capture    = start_now & (is_tdm | ~right_next);

    // ------------------------------------------------------------------
    // Slot walker
    // ------------------------------------------------------------------
    atsm_pkg::atsm_state_t st_reg;
    atsm_pkg::atsm_state_t st_next;
    logic [5:0] dly_reg;
    logic [5:0] dly_next;
    logic [4:0] slot_reg;
    logic [4:0] slot_next;
    logic [4:0] bit_reg;
    logic [4:0] bit_next;
    logic       right_reg;

    always_comb begin
        st_next   = st_reg;
        dly_next  = dly_reg;
        slot_next = slot_reg;
        bit_next  = bit_reg;
        if (frame_start) begin
            slot_next = 5'h00;
            bit_next  = 5'h00;
            dly_next  = delay_eff;
            st_next   = (delay_eff == 6'h00) ? atsm_pkg::ST_RUN : atsm_pkg::ST_DELAY; // [RQ9]
        end else begin
            case (st_reg)
                atsm_pkg::ST_DELAY: begin
                    dly_next = 6'(dly_reg - 6'h01);               // [RQ9]
                    if (dly_reg == 6'h01) st_next = atsm_pkg::ST_RUN;
                end
                atsm_pkg::ST_RUN: begin
                    if (bit_reg == last_bit) begin
                        bit_next = 5'h00;
                        if (slot_reg == last_slot) st_next = atsm_pkg::ST_DONE;
                        else slot_next = 5'(slot_reg + 5'h01);
                    end else begin
                        bit_next = 5'(bit_reg + 5'h01);
                    end
                end
                default: st_next = st_reg;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            st_reg    <= atsm_pkg::ST_IDLE;
            dly_reg   <= 6'h00;
            slot_reg  <= 5'h00;
            bit_reg   <= 5'h00;
            right_reg <= 1'b0;
        end else if (bclk_rise) begin
            st_reg    <= st_next;
            dly_reg   <= dly_next;
            slot_reg  <= slot_next;
            bit_reg   <= bit_next;
            if (frame_start) right_reg <= right_next;
        end
    end

    // Half-frame formats fold the field's top bit into the left/right choice
    wire [4:0] cur_slot   = is_tdm ? slot_reg : {right_reg, slot_reg[3:0]}; // [RQ4] [RQ5]
    wire       slot_valid = (st_reg == atsm_pkg::ST_RUN);

    // ------------------------------------------------------------------
    // Channels
    // ------------------------------------------------------------------
    wire [1:0] ch3_src = ch3_cfg_reg[atsm_pkg::SRC_LSB +: 2];
    wire [2:0] ch_en;
    wire [4:0] ch_slot [3];
    wire [SAMPLE_W-1:0] ch_sample [3];
    wire [2:0] ch_hit;
    wire [2:0] ch_bit;

    assign ch_en[0] = ch1_cfg_reg[atsm_pkg::SRC_LSB];                 // [RQ1]
    assign ch_en[1] = ch2_cfg_reg[atsm_pkg::SRC_LSB];                 // [RQ2]
    // Reserved source code is treated as tri-state
    assign ch_en[2] = (ch3_src == atsm_pkg::CH3_SRC_MIC) |
                      (ch3_src == atsm_pkg::CH3_SRC_VBAT);            // [RQ3]
    assign ch_slot[0] = ch1_cfg_reg[atsm_pkg::SLOT_LSB +: atsm_pkg::SLOT_W];
    assign ch_slot[1] = ch2_cfg_reg[atsm_pkg::SLOT_LSB +: atsm_pkg::SLOT_W];
    assign ch_slot[2] = ch3_cfg_reg[atsm_pkg::SLOT_LSB +: atsm_pkg::SLOT_W];
    assign ch_sample[0] = ch1_sample;
    assign ch_sample[1] = ch2_sample;
    assign ch_sample[2] = (ch3_src == atsm_pkg::CH3_SRC_VBAT) ? ch3_vbat_sample
                                                              : ch3_mic_sample; // [RQ3]

    for (genvar i = 0; i < 3; i++) begin : g_chan
        atsm_chan_slot #(
            .DW         (SAMPLE_W)
        ) u_chan (
            .mclk       (mclk),
            .reset      (reset),
            .capture    (capture),
            .sample_in  (ch_sample[i]),
            .enable     (ch_en[i]),
            .slot_index (ch_slot[i]),
            .cur_slot   (cur_slot),
            .slot_valid (slot_valid),
            .bit_idx    (bit_reg),
            .hit        (ch_hit[i]),
            .bit_out    (ch_bit[i])
        );
    end

    // ------------------------------------------------------------------
    // Pin routing and output stage
    // ------------------------------------------------------------------
    wire [2:0] pin_sel  = pin_sel_reg[2:0];
    wire [2:0] pri_hits = ch_hit & ~pin_sel;                          // [RQ8]
    wire [2:0] sec_hits = ch_hit & pin_sel;                           // [RQ8]
    wire       pri_bit  = atsm_pkg::pick_bit(pri_hits, ch_bit);
    wire       sec_bit  = atsm_pkg::pick_bit(sec_hits, ch_bit);

    logic dout_reg;
    logic dout_oe_n_reg;
    logic sec_reg;
    logic sec_oe_n_reg;

    // Launch on falling bit clock so the host samples a settled bit on the rise
    always_ff @(posedge mclk) begin
        if (reset) begin
            dout_reg      <= 1'b0;
            dout_oe_n_reg <= 1'b1;
            sec_reg       <= 1'b0;
            sec_oe_n_reg  <= 1'b1;
        end else if (bclk_fall) begin
            dout_reg      <= pri_bit;
            dout_oe_n_reg <= ~(|pri_hits);                            // [RQ1] [RQ2] [RQ3]
            sec_reg       <= sec_bit;
            sec_oe_n_reg  <= ~(|sec_hits);                            // [RQ8]
        end
    end

    assign dout_o                        = dout_reg;
    assign dout_oe_n                     = dout_oe_n_reg;
    assign secondary_serial_out_pin_o    = sec_reg;
    assign secondary_serial_out_pin_oe_n = sec_oe_n_reg;

endmodule

`default_nettype wire

/* atsm_pkg.sv */
// Constants shared by the transmit slot mapper for output channels one to three.
// Assumes an 8-bit register port and a serial port clocked by the far party.
package atsm_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] SLOT_ZERO_MSB_DELAY_ADDR = 8'h1c;
    localparam logic [7:0] OUT_PIN_SEL_ADDR         = 8'h1d;
    localparam logic [7:0] OUT_CH_ONE_CONFIG_ADDR   = 8'h1e;
    localparam logic [7:0] OUT_CH_TWO_CONFIG_ADDR   = 8'h1f;
    localparam logic [7:0] OUT_CH_THREE_CONFIG_ADDR = 8'h20;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] SLOT_ZERO_MSB_DELAY_RST  = 8'h00;
    localparam logic [7:0] OUT_PIN_SEL_RST          = 8'h00;
    localparam logic [7:0] OUT_CH_ONE_CONFIG_RST    = 8'h20;
    localparam logic [7:0] OUT_CH_TWO_CONFIG_RST    = 8'h21;
    localparam logic [7:0] OUT_CH_THREE_CONFIG_RST  = 8'h02;

    // ------------------------------------------------------------------
    // Field layout and writable masks
    // ------------------------------------------------------------------
    localparam int         SLOT_LSB      = 0;
    localparam int         SLOT_W        = 5;
    localparam int         SRC_LSB       = 5;
    localparam int         DELAY_W       = 5;
    localparam logic [7:0] CH12_MASK     = 8'h3f;
    localparam logic [7:0] CH3_MASK      = 8'h7f;
    localparam logic [7:0] DELAY_MASK    = 8'h1f;
    localparam logic [7:0] PIN_SEL_MASK  = 8'h07;

    // Channel three source codes
    localparam logic [1:0] CH3_SRC_TRI   = 2'h0;
    localparam logic [1:0] CH3_SRC_MIC   = 2'h1;
    localparam logic [1:0] CH3_SRC_VBAT  = 2'h2;

    // ------------------------------------------------------------------
    // Framing and timing
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        FMT_TDM = 2'b00,
        FMT_I2S = 2'b01,
        FMT_LJ  = 2'b10
    } atsm_fmt_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_DELAY = 2'b01,
        ST_RUN   = 2'b10,
        ST_DONE  = 2'b11
    } atsm_state_t;

    localparam logic [4:0] TDM_LAST_SLOT  = 5'h1f;
    localparam logic [4:0] HALF_LAST_SLOT = 5'h0f;
    localparam logic [5:0] I2S_EXTRA_BITS = 6'h01;
    localparam int         SAMPLE_W       = 32;

    // Last bit index of a slot for word length 16, 20, 24 or 32
    function automatic logic [4:0] word_last(input logic [1:0] sel);
        logic [4:0] r;
        r = 5'h1f;
        case (sel)
            2'h0: r = 5'h0f;
            2'h1: r = 5'h13;
            2'h2: r = 5'h17;
            default: r = 5'h1f;
        endcase
        return r;
    endfunction

    // First channel in the hit set wins the pin
    function automatic logic pick_bit(input logic [2:0] hits, input logic [2:0] bits);
        logic r;
        r = 1'b0;
        if (hits[0]) r = bits[0];
        else if (hits[1]) r = bits[1];
        else r = bits[2];
        return r;
    endfunction

endpackage

/* atsm_chan_slot.sv */
// One output channel: holds its frame sample and says when its slot is on air.
// Assumes capture, cur_slot and bit_idx come from the mclk-domain slot walker.
`timescale 1ns/10ps
`default_nettype none

module atsm_chan_slot #(
    parameter int DW = 32
) (
    input  wire logic          mclk,
    input  wire logic          reset,
    input  wire logic          capture,
    input  wire logic [DW-1:0] sample_in,
    input  wire logic          enable,
    input  wire logic [4:0]    slot_index,
    input  wire logic [4:0]    cur_slot,
    input  wire logic          slot_valid,
    input  wire logic [4:0]    bit_idx,
    output logic               hit,
    output logic               bit_out
);

    // Bit index is five bits wide, so only a 32-bit word fits
    if (DW != 32) begin : g_bad_width
        $error("atsm_chan_slot: DW must be 32");
    end

    logic [DW-1:0] sample_reg;
    wire  [4:0]    msb_first_idx = 5'h1f - bit_idx;

    always_ff @(posedge mclk) begin
        if (reset) sample_reg <= '0;
        else if (capture) sample_reg <= sample_in;
    end

    // Disabled channel never claims the pin, so it stays high impedance
    assign hit     = enable & slot_valid & (slot_index == cur_slot);
    assign bit_out = sample_reg[msb_first_idx];

endmodule

`default_nettype wire

/* atsm_tx_mapper_sva.sv */
// Port-level checks of the slot mapper register port and pin enables.
// Assumes it is bound into atsm_tx_mapper and sees only its ports.
`timescale 1ns/10ps
`default_nettype none

module atsm_tx_mapper_sva (
    input wire logic       mclk,
    input wire logic       reset,
    input wire logic [7:0] reg_addr,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic       dout_oe_n,
    input wire logic       secondary_serial_out_pin_oe_n
);
    // ------------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    wire logic mapped = (reg_addr >= 8'h1c) && (reg_addr <= 8'h20);

    property p_unmapped_zero;
        reg_rd && !mapped |=> reg_rdata == 8'h00;
    endproperty
    a_unmapped_zero: assert property (p_unmapped_zero)
        else $error("unmapped read not zero");
    property p_rsv_ch12;
        reg_rd && (reg_addr == 8'h1e || reg_addr == 8'h1f) |=> reg_rdata[7:6] == 2'h0;
    endproperty
    a_rsv_ch12: assert property (p_rsv_ch12)
        else $error("reserved bits 7:6 set");
    property p_rsv_ch3;
        reg_rd && reg_addr == 8'h20 |=> !reg_rdata[7];
    endproperty
    a_rsv_ch3: assert property (p_rsv_ch3)
        else $error("reserved bit 7 set");
    property p_rd_holds;
        !reg_rd |=> $stable(reg_rdata);
    endproperty
    a_rd_holds: assert property (p_rd_holds)
        else $error("read data moved without read");
    property p_wr_rd_ch1;
        reg_wr && !reg_rd && reg_addr == 8'h1e ##1 reg_rd && !reg_wr && reg_addr == 8'h1e
            |=> reg_rdata == ($past(reg_wdata, 2) & 8'h3f);
    endproperty
    a_wr_rd_ch1: assert property (p_wr_rd_ch1)
        else $error("channel one config read-back wrong");
    property p_wr_rd_ch3;
        reg_wr && !reg_rd && reg_addr == 8'h20 ##1 reg_rd && !reg_wr && reg_addr == 8'h20
            |=> reg_rdata == ($past(reg_wdata, 2) & 8'h7f);
    endproperty
    a_wr_rd_ch3: assert property (p_wr_rd_ch3)
        else $error("channel three config read-back wrong");
    property p_wr_rd_pin;
        reg_wr && !reg_rd && reg_addr == 8'h1d ##1 reg_rd && !reg_wr && reg_addr == 8'h1d
            |=> reg_rdata == ($past(reg_wdata, 2) & 8'h07);
    endproperty
    a_wr_rd_pin: assert property (p_wr_rd_pin)
        else $error("pin select read-back wrong");
    property p_reset_idle;
        $fell(reset) |-> dout_oe_n && secondary_serial_out_pin_oe_n && reg_rdata == 8'h00;
    endproperty
    a_reset_idle: assert property (p_reset_idle)
        else $error("outputs not idle after reset");
    c_ch1_write: cover property (reg_wr && reg_addr == 8'h1e);
    c_primary_on: cover property ($fell(dout_oe_n));
    c_secondary_on: cover property ($fell(secondary_serial_out_pin_oe_n));
endmodule

bind atsm_tx_mapper atsm_tx_mapper_sva u_sva (
    .mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .dout_oe_n(dout_oe_n),
    .secondary_serial_out_pin_oe_n(secondary_serial_out_pin_oe_n));
`default_nettype wire

/* atsm_host_model.sv */
// Receiving host: makes bit clock and frame sync, samples both data pins.
// Assumes a 10 ns mclk; the bit clock stands still between bursts.
`timescale 1ns/10ps
`default_nettype none

module atsm_host_model (
    input  wire logic  mclk,
    input  wire logic  d1,
    input  wire logic  oe1_n,
    input  wire logic  d2,
    input  wire logic  oe2_n,
    output logic       bclk,
    output logic       fsync,
    output logic       smp,
    output logic [3:0] rx
);
    logic last1 = 1'b0;
    logic last2 = 1'b0;
    // Released lines show the inverse of the last driven bit
    wire logic ln1 = oe1_n ? ~last1 : d1;
    wire logic ln2 = oe2_n ? ~last2 : d2;

    initial begin
        bclk = 1'b0;
        fsync = 1'b0;
        smp = 1'b0;
        rx = 4'h0;
    end
    always @(posedge mclk) begin
        if (!oe1_n) last1 <= d1;
        if (!oe2_n) last2 <= d2;
    end

    // ------------------------------------------------------------------
    // 80 ns bit clock, four mclk per phase
    // ------------------------------------------------------------------
    task automatic phase(input logic v, input logic take);
        bclk = v;
        smp = take;
        if (take) rx = {oe1_n, ln1, oe2_n, ln2};
        @(negedge mclk);
        smp = 1'b0;
        repeat (3) @(negedge mclk);
    endtask

    // Idle clock first so every half start is an edge of frame sync
    task automatic run(input logic lvl, input logic pulse, input int n, input int halves);
        fsync = ~lvl;
        phase(1'b1, 1'b0);
        phase(1'b0, 1'b0);
        for (int h = 0; h < halves; h++) begin
            fsync = lvl ^ h[0];
            phase(1'b1, 1'b0);
            phase(1'b0, 1'b0);
            if (pulse) fsync = 1'b0;
            for (int k = 1; k < n; k++) begin
                phase(1'b1, 1'b1);
                phase(1'b0, 1'b0);
            end
        end
    endtask
endmodule
`default_nettype wire

/* test_atsm_tx_mapper.sv */
// Self-checking bench of the slot mapper: register port and both data pins.
// Assumes the host model makes an 80 ns bit clock and samples on its rise.
`timescale 1ns/10ps
`default_nettype none

module test_atsm_tx_mapper;
    typedef struct packed {logic oe1_n; logic d1; logic oe2_n; logic d2;} atsm_note_t;
    logic        mclk, reset, reg_wr, reg_rd, bclk_pin, fsync_pin, smp;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata;
    logic [1:0]  fmt, word_len_sel;
    logic [31:0] s1, s2, s3m, s3v;
    logic        dout_o, dout_oe_n, sec_o, sec_oe_n;
    logic [3:0]  rx;
    logic [7:0]  regs [5];
    atsm_note_t  notes [$];
    int          num_errors = 0;
    int          n_checks = 0;

    atsm_tx_mapper dut (.mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .fmt(fmt),
        .word_len_sel(word_len_sel), .bclk_pin(bclk_pin), .fsync_pin(fsync_pin),
        .ch1_sample(s1), .ch2_sample(s2), .ch3_mic_sample(s3m), .ch3_vbat_sample(s3v),
        .dout_o(dout_o), .dout_oe_n(dout_oe_n), .secondary_serial_out_pin_o(sec_o),
        .secondary_serial_out_pin_oe_n(sec_oe_n));
    atsm_host_model host (.mclk(mclk), .d1(dout_o), .oe1_n(dout_oe_n), .d2(sec_o),
        .oe2_n(sec_oe_n), .bclk(bclk_pin), .fsync(fsync_pin), .smp(smp), .rx(rx));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // ------------------------------------------------------------------
    // Checking and register access
    // ------------------------------------------------------------------
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] e);
        n_checks++;
        if (seen !== e) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, e, seen);
        end
    endtask
    task automatic conclude();
        $display("Checks made %0d, mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge mclk);
        reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge mclk);
        reg_rd = 1'b0;
        @(negedge mclk);
        check("reg_rdata", reg_rdata, e);
    endtask
    task automatic cfg(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] m;
        m = (a == 8'h1c) ? 8'h1f : (a == 8'h1d) ? 8'h07 : (a == 8'h20) ? 8'h7f : 8'h3f;
        regs[a - 8'h1c] = d & m;
        wr(a, d & m);
        rd(a, d & m);
    endtask

    // Expected pins for walker position q in half r; lower channel wins a slot
    function automatic atsm_note_t expect_bit(input int q, input logic r);
        atsm_note_t n;
        logic [7:0] c;
        logic [31:0] s;
        logic hit;
        int w;
        n = 4'ha;
        w = (word_len_sel == 2'h3) ? 32 : 16 + 4 * int'(word_len_sel);
        if (q < 0 || q >= ((fmt == atsm_pkg::FMT_TDM) ? 32 : 16) * w) return n;
        for (int i = 2; i >= 0; i--) begin
            c = regs[2 + i];
            s = (i == 0) ? s1 : (i == 1) ? s2 : c[6] ? s3v : s3m;
            hit = (fmt == atsm_pkg::FMT_TDM) ? c[4:0] == 5'(q / w)
                : c[4:0] == {r, 4'(q / w)};
            hit = hit && ((i < 2) ? c[5] : c[6] != c[5]);
            if (hit && regs[1][i]) n[1:0] = {1'b0, s[31 - q % w]};
            else if (hit) n[3:2] = {1'b0, s[31 - q % w]};
        end
        return n;
    endfunction

    task automatic burst(input int n, input int halves);
        int dly;
        dly = int'(regs[0][4:0]) + ((fmt == atsm_pkg::FMT_I2S) ? 1 : 0);
        for (int h = 0; h < halves; h++)
            for (int k = 1; k < n; k++)
                notes.push_back(expect_bit(k - 1 - dly, h[0]));
        host.run(fmt != atsm_pkg::FMT_I2S, fmt == atsm_pkg::FMT_TDM, n, halves);
        repeat (2) @(negedge mclk);
        if (notes.size() != 0) begin
            num_errors++;
            $display("Error pin samples expected 0 left seen %0d", notes.size());
            conclude();
        end
    endtask
    task automatic scen(input logic [1:0] f, input logic [1:0] wl, input logic [39:0] v,
                        input int n, input int h);
        fmt = f;
        word_len_sel = wl;
        s1 = $urandom();
        s2 = $urandom();
        s3m = $urandom();
        s3v = $urandom();
        for (int i = 0; i < 5; i++) cfg(8'h1c + 8'(i), v[8*i +: 8]);
        burst(n, h);
    endtask

    always @(posedge mclk) begin
        atsm_note_t nt;
        if (smp === 1'b1) begin
            if (notes.size() == 0) begin
                num_errors++;
                $display("Error pin sample expected none seen %h", rx);
            end else begin
                nt = notes.pop_front();
                check("dout_oe_n", 8'(rx[3]), 8'(nt.oe1_n));
                if (!nt.oe1_n) check("dout_o", 8'(rx[2]), 8'(nt.d1));
                check("sec_oe_n", 8'(rx[1]), 8'(nt.oe2_n));
                if (!nt.oe2_n) check("sec_o", 8'(rx[0]), 8'(nt.d2));
            end
        end
    end

    initial begin
        repeat (100000) @(posedge mclk);
        num_errors++;
        $display("Error run expected done seen timeout");
        conclude();
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        reset = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        fmt = atsm_pkg::FMT_TDM;
        word_len_sel = 2'h0;
        regs = '{8'h00, 8'h00, 8'h20, 8'h21, 8'h02};
        void'($urandom(32'h4eb2));
        s1 = $urandom();
        s2 = $urandom();
        s3m = $urandom();
        s3v = $urandom();
        repeat (4) @(negedge mclk);
        reset = 1'b0;
        @(negedge mclk);
        for (int i = 0; i < 5; i++) rd(8'h1c + 8'(i), regs[i]);
        rd(8'h21, 8'h00);
        burst(96, 1);
        for (int i = 0; i < 5; i++) cfg(8'h1c + 8'(i), 8'hff);
        wr(8'h21, 8'hff);
        rd(8'h21, 8'h00);
        // Slot 31, channel one off, mic on secondary pin
        scen(atsm_pkg::FMT_TDM, 2'h0, 40'h22_3f_00_04_00, 512, 1);
        // 32-bit words, battery source, delay 3
        scen(atsm_pkg::FMT_TDM, 2'h3, 40'h45_21_20_02_03, 200, 1);
        // Shared slot, reserved source, delay 31, 24-bit words
        scen(atsm_pkg::FMT_TDM, 2'h2, 40'h62_20_20_00_1f, 96, 1);
        scen(atsm_pkg::FMT_I2S, 2'h0, 40'h31_01_30_00_00, 40, 2);
        scen(atsm_pkg::FMT_LJ, 2'h1, 40'h42_31_20_05_01, 64, 2);
        conclude();
    end
endmodule
`default_nettype wire
